// file: logic/pss_supervisor.sv
// Supervisory state machine, scaling, fault flags and interrupt of the power manager
`timescale 1ns/1ps
// Overview of operation
// - Each output not kept on in that sleep state waits its five-bit turn-off delay after sleep or deep-sleep entry before shutting down.
// - Shared soft-start bit picks 500 us when clear, 250 us when set.
// - Bucks use active code normally and scaled code while scaling trigger is active.
// - Linear regulators use one eight-bit code; all codes writable, reset to defaults.
// - A rewritten code moves that output's fault thresholds to the new target at once.
// - Enable clear: host scaling off; enable set, source zero: request bit decides.
// - Enable set, source one: scaling follows the sleep state, request ignored.
// - Deep sleep never activates voltage scaling.
// - Outputs stay off until input exceeds the monitor threshold after undervoltage release.
// - Input below monitor raises interrupt only; undervoltage shuts the system down.
// - Latched input-low flag clears on read, mask defaults set, live flag follows.
// - Each fault has a status bit always reporting and a mask gating the interrupt.
// - Unmasked fault pulls interrupt low; thermal and output faults release it when gone, input-low and current warnings also need a status read.
// - Input undervoltage: reset state, outputs off, reset low, restart when input good.
// - Input overvoltage: reset state, outputs off, reset low, restart when it falls.
// - Unmasked output fault: outputs off, reset low, restart after 10 ms.
// - Masked output fault keeps interrupt high and avoids fault state; status still live.
// - Buck current warning after 16 consecutive cycles above 75 percent of limit.
// - Over 125 C warns, mask defaults set; over 155 C disables all outputs at once.
// - Power-mode pin is filtered both ways before acting on it.
// - Scaling pin held low puts its buck into scaling.
module pss_supervisor
  import pss_pkg::*;
#(
  parameter int unsigned RESTART_CYCLES = RESTART_CYC,
  parameter int unsigned OFF_DLY_UNIT = OFF_DLY_UNIT_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire pss_sense_t sense_i,
  input wire logic power_mode_pin_i,
  input wire logic sleep_request_i,
  input wire logic deep_sleep_enable_i,
  input wire logic [BUCK_CNT-1:0] scaling_pin_n_i,
  input wire pss_scale_cfg_t scale_cfg_i,
  input wire logic soft_start_fast_i,
  input wire logic [OUT_CNT*5-1:0] turn_off_delay_field_i,
  input wire logic [OUT_CNT-1:0] sleep_keep_on_i,
  input wire logic [OUT_CNT-1:0] deep_sleep_keep_on_i,
  input wire logic [BUCK_CNT*8-1:0] active_voltage_code_i,
  input wire logic [BUCK_CNT*8-1:0] scaled_voltage_code_i,
  input wire logic [LDO_CNT*8-1:0] linear_voltage_code_i,
  input wire logic [BUCK_CNT-1:0] sw_cycle_i,
  input wire logic [BUCK_CNT-1:0] ilim_over_thr_i,
  input wire logic input_low_mask_i,
  input wire logic therm_mask_i,
  input wire logic [BUCK_CNT-1:0] ilim_mask_i,
  input wire logic [OUT_CNT-1:0] out_uv_mask_i,
  input wire logic [OUT_CNT-1:0] out_ov_mask_i,
  input wire logic disable_outfault_shdn_i,
  input wire logic status_read_i,
  output logic [OUT_CNT-1:0] out_enable_o,
  output logic [OUT_CNT*8-1:0] target_code_o,
  output logic [OUT_CNT*8-1:0] fault_thr_code_o,
  output logic [BUCK_CNT-1:0] voltage_scaling_o,
  output logic [15:0] soft_start_cycles_o,
  output logic input_low_latched_flag_o,
  output logic input_low_live_flag_o,
  output logic therm_warn_flag_o,
  output logic [BUCK_CNT-1:0] current_warning_flag_o,
  output logic [OUT_CNT-1:0] out_uv_flag_o,
  output logic [OUT_CNT-1:0] out_ov_flag_o,
  output logic interrupt_out_n_o,
  output logic system_reset_out_n_o,
  output pss_state_t state_o
);
  localparam int unsigned RW = $clog2(RESTART_CYCLES + 1);
  localparam int unsigned DW = $clog2(32 * OFF_DLY_UNIT + 1);

  pss_state_t state_r, state_nxt;
  logic [RW-1:0] restart_cnt_r;
  logic [DW-1:0] off_cnt_r;
  logic [OUT_CNT-1:0] out_en_r, out_en_nxt;
  logic [OUT_CNT*8-1:0] target_r, target_nxt;
  logic [BUCK_CNT-1:0] scal_r;
  logic [15:0] ss_r;
  logic in_low_lat_r, in_low_live_r, therm_r;
  logic [BUCK_CNT-1:0] ilim_lat_r;
  logic [OUT_CNT-1:0] uv_r, ov_r;
  logic irq_n_r, rst_out_n_r;
  logic pmode_filt;
  logic [BUCK_CNT-1:0] ilim_warn;

  pss_glitch_filter #(
    .FILT_CYC(PMODE_FILT_CYC),
    .RST_VAL(1'b1)
  ) u_pmode_filt (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .raw_i(power_mode_pin_i),
    .filt_o(pmode_filt)
  );

  genvar gi;
  generate
    for (gi = 0; gi < BUCK_CNT; gi++) begin : g_ilim
      pss_ilim_watch #(
        .RUN_LEN(ILIM_RUN_LEN)
      ) u_ilim (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .sw_cycle_i(sw_cycle_i[gi]),
        .over_thr_i(ilim_over_thr_i[gi]),
        .warn_o(ilim_warn[gi])
      );
    end
  endgenerate

  // Input supply qualification
  wire in_bad = sense_i.in_uv || sense_i.in_ov;
  wire in_good = !in_bad && sense_i.in_above_mon;
  wire in_low = !sense_i.in_above_mon;
  wire sleep_go = sleep_request_i;
  wire deep_go = deep_sleep_enable_i && !pmode_filt;
  wire [OUT_CNT-1:0] trip_uv = sense_i.out_uv & ~out_uv_mask_i;
  wire [OUT_CNT-1:0] trip_ov = sense_i.out_ov & ~out_ov_mask_i;
  wire out_trip = |(trip_uv | trip_ov) && !disable_outfault_shdn_i;

  // Host scaling decode; deep sleep never enters the term
  wire host_scal = scale_cfg_i.host_scaling_enable
    && (scale_cfg_i.scaling_source_select ? (state_r == PSS_ST_SLEEP)
        : scale_cfg_i.host_scaling_request);
  wire [BUCK_CNT-1:0] scal_nxt = ~scaling_pin_n_i | {BUCK_CNT{host_scal}};

  // Selected codes also serve as fault thresholds right away
  always_comb begin
    target_nxt = '0;
    for (int i = 0; i < BUCK_CNT; i++) begin
      target_nxt[i*8 +: 8] = scal_nxt[i] ? scaled_voltage_code_i[i*8 +: 8]
                                         : active_voltage_code_i[i*8 +: 8];
    end
    for (int j = 0; j < LDO_CNT; j++) begin
      target_nxt[(BUCK_CNT+j)*8 +: 8] = linear_voltage_code_i[j*8 +: 8];
    end
  end

  function automatic logic [DW-1:0] off_delay(input logic [4:0] fld);
    off_delay = DW'(fld) * DW'(OFF_DLY_UNIT);
  endfunction : off_delay

  // Power-down mask of the low-power states with per-output turn-off delay
  always_comb begin
    logic [OUT_CNT-1:0] keep;
    keep = (state_r == PSS_ST_SLEEP) ? sleep_keep_on_i : deep_sleep_keep_on_i;
    out_en_nxt = out_en_r;
    case (state_r)
      PSS_ST_SEQ_START, PSS_ST_ACTIVE: out_en_nxt = '1;
      PSS_ST_SLEEP, PSS_ST_DEEP_SLEEP: begin
        for (int k = 0; k < OUT_CNT; k++) begin
          if (keep[k]) begin
            out_en_nxt[k] = 1'b1;
          end else if (off_cnt_r >= off_delay(turn_off_delay_field_i[k*5 +: 5])) begin
            out_en_nxt[k] = 1'b0;
          end
        end
      end
      default: out_en_nxt = '0;
    endcase
  end

  // State sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PSS_ST_RESET: if (in_good) state_nxt = PSS_ST_SEQ_START;
      PSS_ST_SEQ_START: state_nxt = PSS_ST_ACTIVE;
      PSS_ST_ACTIVE: begin
        if (deep_go) state_nxt = PSS_ST_DEEP_SLEEP;
        else if (sleep_go) state_nxt = PSS_ST_SLEEP;
      end
      PSS_ST_SLEEP: if (!sleep_go || deep_go) state_nxt = PSS_ST_ACTIVE;
      PSS_ST_DEEP_SLEEP: if (!deep_go) state_nxt = PSS_ST_ACTIVE;
      PSS_ST_OUT_FAULT: begin
        if (restart_cnt_r == RW'(RESTART_CYCLES - 1)) state_nxt = PSS_ST_SEQ_START;
      end
      PSS_ST_THERMAL: if (!sense_i.therm_shdn) state_nxt = PSS_ST_RESET;
      default: state_nxt = PSS_ST_RESET;
    endcase
    if (state_r != PSS_ST_RESET && state_r != PSS_ST_THERMAL && state_r != PSS_ST_OUT_FAULT
        && out_trip) begin
      state_nxt = PSS_ST_OUT_FAULT;
    end
    if (sense_i.therm_shdn) state_nxt = PSS_ST_THERMAL;
    if (in_bad) state_nxt = PSS_ST_RESET;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= PSS_ST_RESET;
      restart_cnt_r <= '0;
      off_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      restart_cnt_r <= (state_r == PSS_ST_OUT_FAULT && state_nxt == state_r)
        ? restart_cnt_r + RW'(1) : '0;
      if (state_nxt != state_r) off_cnt_r <= '0;
      else if (off_cnt_r != '1) off_cnt_r <= off_cnt_r + DW'(1);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_en_r <= '0;
      target_r <= {OUT_CNT{VCODE_RST}};
      scal_r <= '0;
      ss_r <= 16'(SS_SLOW_CYC);
    end else begin
      out_en_r <= out_en_nxt;
      target_r <= target_nxt;
      scal_r <= scal_nxt;
      ss_r <= soft_start_fast_i ? 16'(SS_FAST_CYC) : 16'(SS_SLOW_CYC);
    end
  end

  // Flags: live bits follow; latched bits hold until cleared and read, set wins
  wire in_low_hold = in_low_lat_r && !(status_read_i && !in_low);
  wire [BUCK_CNT-1:0] ilim_hold = ilim_lat_r & ~({BUCK_CNT{status_read_i}} & ~ilim_warn);
  wire irq_req = (in_low_lat_r && !input_low_mask_i) || (therm_r && !therm_mask_i)
    || |(ilim_lat_r & ~ilim_mask_i) || |(uv_r & ~out_uv_mask_i)
    || |(ov_r & ~out_ov_mask_i);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_low_lat_r <= 1'b0;
      in_low_live_r <= 1'b0;
      therm_r <= 1'b0;
      ilim_lat_r <= '0;
      uv_r <= '0;
      ov_r <= '0;
      irq_n_r <= 1'b1;
      rst_out_n_r <= 1'b0;
    end else begin
      in_low_lat_r <= in_low || in_low_hold;
      in_low_live_r <= in_low;
      therm_r <= sense_i.therm_warn;
      ilim_lat_r <= ilim_warn | ilim_hold;
      uv_r <= sense_i.out_uv;
      ov_r <= sense_i.out_ov;
      irq_n_r <= !irq_req;
      rst_out_n_r <= (state_nxt == PSS_ST_ACTIVE || state_nxt == PSS_ST_SLEEP
        || state_nxt == PSS_ST_DEEP_SLEEP);
    end
  end

  assign out_enable_o = out_en_r;
  assign target_code_o = target_r;
  assign fault_thr_code_o = target_r;
  assign voltage_scaling_o = scal_r;
  assign soft_start_cycles_o = ss_r;
  assign input_low_latched_flag_o = in_low_lat_r;
  assign input_low_live_flag_o = in_low_live_r;
  assign therm_warn_flag_o = therm_r;
  assign current_warning_flag_o = ilim_lat_r;
  assign out_uv_flag_o = uv_r;
  assign out_ov_flag_o = ov_r;
  assign interrupt_out_n_o = irq_n_r;
  assign system_reset_out_n_o = rst_out_n_r;
  assign state_o = state_r;
endmodule : pss_supervisor

// file: common/pss_pkg.sv
// Shared constants and types of the power supervisor
package pss_pkg;
  localparam int unsigned CLK_FREQ_HZ = 10_000_000;
  localparam int unsigned BUCK_CNT = 3;
  localparam int unsigned LDO_CNT = 2;
  localparam int unsigned OUT_CNT = 5;
  localparam int unsigned RESTART_DLY_MS = 10;
  localparam int unsigned RESTART_CYC = (CLK_FREQ_HZ / 1000) * RESTART_DLY_MS;
  localparam int unsigned SS_SLOW_US = 500;
  localparam int unsigned SS_FAST_US = 250;
  localparam int unsigned SS_SLOW_CYC = (CLK_FREQ_HZ / 1_000_000) * SS_SLOW_US;
  localparam int unsigned SS_FAST_CYC = (CLK_FREQ_HZ / 1_000_000) * SS_FAST_US;
  localparam int unsigned ILIM_RUN_LEN = 16;
  localparam int unsigned PMODE_FILT_CYC = 8;
  localparam int unsigned OFF_DLY_UNIT_CYC = 100;
  localparam logic [7:0] VCODE_RST = 8'h40;
  localparam logic [4:0] OFF_DLY_RST = 5'h01;
  localparam logic SS_SEL_RST = 1'b0;
  localparam logic IN_LOW_MASK_RST = 1'b1;
  localparam logic THERM_MASK_RST = 1'b1;
  localparam logic [7:0] STATUS_REG_ADDR = 8'h00;

  typedef enum logic [2:0] {
    PSS_ST_RESET, PSS_ST_SEQ_START, PSS_ST_ACTIVE, PSS_ST_SLEEP, PSS_ST_DEEP_SLEEP,
    PSS_ST_OUT_FAULT, PSS_ST_THERMAL
  } pss_state_t;

  // Analog comparator results, synchronous to clk_sys_i
  typedef struct packed {
    logic in_uv;
    logic in_above_mon;
    logic in_ov;
    logic therm_warn;
    logic therm_shdn;
    logic [OUT_CNT-1:0] out_uv;
    logic [OUT_CNT-1:0] out_ov;
  } pss_sense_t;

  // Scaling controls from the host
  typedef struct packed {
    logic host_scaling_enable;
    logic scaling_source_select;
    logic host_scaling_request;
  } pss_scale_cfg_t;
endpackage : pss_pkg

// file: logic/pss_glitch_filter.sv
// Two-way glitch filter for a slow control pin
`timescale 1ns/1ps
module pss_glitch_filter #(
  parameter int unsigned FILT_CYC = 8,
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic raw_i,
  output logic filt_o
);
  localparam int unsigned CW = $clog2(FILT_CYC + 1);
  logic [CW-1:0] cnt_r;
  logic filt_r;
  wire differs = raw_i != filt_r;
  wire done = cnt_r == CW'(FILT_CYC - 1);

  // Level must hold steadily before it is taken, rising and falling alike
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
      filt_r <= RST_VAL;
    end else if (!differs) begin
      cnt_r <= '0;
    end else if (done) begin
      cnt_r <= '0;
      filt_r <= raw_i;
    end else begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  assign filt_o = filt_r;
endmodule : pss_glitch_filter

// file: logic/pss_ilim_watch.sv
// Counts consecutive over-threshold switching cycles of one buck
`timescale 1ns/1ps
module pss_ilim_watch #(
  parameter int unsigned RUN_LEN = 16
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic sw_cycle_i,
  input wire logic over_thr_i,
  output logic warn_o
);
  localparam int unsigned CW = $clog2(RUN_LEN + 1);
  logic [CW-1:0] run_r;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_r <= '0;
    end else if (sw_cycle_i) begin
      if (!over_thr_i) begin
        run_r <= '0;
      end else if (run_r != CW'(RUN_LEN)) begin
        run_r <= run_r + CW'(1);
      end
    end
  end

  assign warn_o = run_r == CW'(RUN_LEN);
endmodule : pss_ilim_watch

// file: bench/pss_sup_monitor.sv
// Port-level checker of the power supervisor
`timescale 1ns/1ps
module pss_sup_monitor
  import pss_pkg::*;
#(
  parameter int unsigned RESTART_CYCLES = 20
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire pss_sense_t sense_i,
  input wire logic [BUCK_CNT-1:0] scaling_pin_n_i,
  input wire pss_scale_cfg_t scale_cfg_i,
  input wire logic soft_start_fast_i,
  input wire logic [OUT_CNT-1:0] out_uv_mask_i,
  input wire logic [LDO_CNT*8-1:0] linear_voltage_code_i,
  input wire logic disable_outfault_shdn_i,
  input wire logic [OUT_CNT-1:0] out_enable_o,
  input wire logic [OUT_CNT*8-1:0] target_code_o,
  input wire logic [OUT_CNT*8-1:0] fault_thr_code_o,
  input wire logic [BUCK_CNT-1:0] voltage_scaling_o,
  input wire logic [15:0] soft_start_cycles_o,
  input wire logic input_low_latched_flag_o,
  input wire logic input_low_live_flag_o,
  input wire logic system_reset_out_n_o,
  input wire pss_state_t state_o
);
  default clocking dcb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  logic [31:0] flt_cnt_r;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flt_cnt_r <= '0;
    end else begin
      flt_cnt_r <= (state_o == PSS_ST_OUT_FAULT) ? flt_cnt_r + 32'h0000_0001 : '0;
    end
  end
  AST_SS_SEL: assert property (1'b1 |=> soft_start_cycles_o ==
    ($past(soft_start_fast_i) ? 16'(SS_FAST_CYC) : 16'(SS_SLOW_CYC)))
    else $error("soft-start count does not follow select");
  AST_BUS_OFF: assert property (!scale_cfg_i.host_scaling_enable && &scaling_pin_n_i
    |=> voltage_scaling_o == '0) else $error("scaling on with host enable clear");
  AST_BUS_ON: assert property (scale_cfg_i == 3'b101 |=> voltage_scaling_o == '1)
    else $error("host request did not start scaling");
  AST_PIN: assert property (!scaling_pin_n_i[0] |=> voltage_scaling_o[0])
    else $error("scaling pin low without scaling");
  AST_THR: assert property (1'b1 |=> fault_thr_code_o == target_code_o
    && fault_thr_code_o[OUT_CNT*8-1:BUCK_CNT*8] == $past(linear_voltage_code_i))
    else $error("fault threshold lags target code");
  AST_LOW: assert property (state_o == PSS_ST_ACTIVE && !sense_i.in_above_mon
    |=> input_low_live_flag_o && input_low_latched_flag_o) else $error("input-low flags idle");
  AST_OUT_FAULT: assert property (state_o == PSS_ST_ACTIVE && sense_i.out_uv[0]
    && !out_uv_mask_i[0] && !disable_outfault_shdn_i
    && !(sense_i.in_uv | sense_i.in_ov | sense_i.therm_shdn) |=> state_o == PSS_ST_OUT_FAULT)
    else $error("output fault state not entered");
  AST_FAULT_OFF: assert property (state_o == PSS_ST_OUT_FAULT
    |=> !system_reset_out_n_o && out_enable_o == '0) else $error("outputs on in fault");
  AST_RESTART_MIN: assert property ($fell(state_o == PSS_ST_OUT_FAULT)
    |-> $past(flt_cnt_r) + 1 == RESTART_CYCLES) else $error("restart came too early");
  AST_RESTART_MAX: assert property (flt_cnt_r <= RESTART_CYCLES)
    else $error("restart came too late");
  AST_THERM: assert property (sense_i.therm_shdn |-> ##2 out_enable_o == '0)
    else $error("outputs on in thermal shutdown");
endmodule : pss_sup_monitor
bind pss_supervisor pss_sup_monitor #(.RESTART_CYCLES(RESTART_CYCLES)) mon_u (
  .clk_sys_i, .rst_n_i, .sense_i, .scaling_pin_n_i, .scale_cfg_i, .soft_start_fast_i,
  .out_uv_mask_i, .linear_voltage_code_i, .disable_outfault_shdn_i, .out_enable_o,
  .target_code_o, .fault_thr_code_o,
  .voltage_scaling_o, .soft_start_cycles_o, .input_low_latched_flag_o, .input_low_live_flag_o,
  .system_reset_out_n_o, .state_o
);

// file: bench/pss_host_model.sv
// Host model: steps voltage codes gently and issues status reads
`timescale 1ns/1ps
module pss_host_model
  import pss_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [7:0] goal_code_i,
  input wire logic read_req_i,
  output logic [BUCK_CNT*8-1:0] active_code_o,
  output logic status_read_o
);
  logic [7:0] code_r;
  logic rd_seen_r;
  assign active_code_o = {BUCK_CNT{code_r}};
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      code_r <= VCODE_RST;
      rd_seen_r <= 1'b0;
      status_read_o <= 1'b0;
    end else begin
      // One step a cycle keeps the output inside its fault window
      code_r <= (code_r < goal_code_i) ? code_r + 8'h01 :
        (code_r > goal_code_i) ? code_r - 8'h01 : code_r;
      status_read_o <= read_req_i && !rd_seen_r;
      rd_seen_r <= read_req_i;
    end
  end
endmodule : pss_host_model

// file: bench/test_pss_supervisor.sv
// Self-checking bench of the power supervisor
`timescale 1ns/1ps
module test_pss_supervisor;
  import pss_pkg::*;
  localparam int unsigned RST_CYC = 20;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  pss_sense_t sense = '0;
  pss_scale_cfg_t cfg = '0;
  pss_state_t st;
  logic pmode = 1'b1, sleep_req = 1'b0, ds_en = 1'b0, ss_fast = 1'b0, in_msk = 1'b1;
  logic th_msk = 1'b1, dis_flt = 1'b0, rd_req = 1'b0, rd, irq_n, rst_o_n, lo_lat, lo_live;
  logic twarn;
  logic [BUCK_CNT-1:0] pin_n = '1, sw_cyc = '0, ilim_thr = '0, scl, iwarn, ilim_msk = '0;
  logic [OUT_CNT-1:0] uv_msk = '0, ov_msk = '0, en, uvf, ovf;
  logic [7:0] goal = 8'h40;
  logic [BUCK_CNT*8-1:0] act;
  logic [OUT_CNT*8-1:0] tgt, thr;
  logic [15:0] ss_cyc;
  int n_errors = 0, num_checks = 0, cyc = 0;
  initial forever #50 clk_sys_i = ~clk_sys_i;
  pss_host_model host_u (.clk_sys_i, .rst_n_i, .goal_code_i(goal), .read_req_i(rd_req),
    .active_code_o(act), .status_read_o(rd));
  pss_supervisor #(.RESTART_CYCLES(RST_CYC), .OFF_DLY_UNIT(2)) dut_u (.clk_sys_i, .rst_n_i,
    .sense_i(sense), .power_mode_pin_i(pmode), .sleep_request_i(sleep_req),
    .deep_sleep_enable_i(ds_en), .scaling_pin_n_i(pin_n), .scale_cfg_i(cfg),
    .soft_start_fast_i(ss_fast), .turn_off_delay_field_i(25'h0C0_8421), .sleep_keep_on_i('1),
    .deep_sleep_keep_on_i('0), .active_voltage_code_i(act), .scaled_voltage_code_i(24'h22_2222),
    .linear_voltage_code_i({2{goal}}), .sw_cycle_i(sw_cyc), .ilim_over_thr_i(ilim_thr),
    .input_low_mask_i(in_msk), .therm_mask_i(th_msk), .ilim_mask_i(ilim_msk),
    .out_uv_mask_i(uv_msk),
    .out_ov_mask_i(ov_msk), .disable_outfault_shdn_i(dis_flt), .status_read_i(rd),
    .out_enable_o(en), .target_code_o(tgt), .fault_thr_code_o(thr), .voltage_scaling_o(scl),
    .soft_start_cycles_o(ss_cyc), .input_low_latched_flag_o(lo_lat),
    .input_low_live_flag_o(lo_live), .therm_warn_flag_o(twarn), .current_warning_flag_o(iwarn),
    .out_uv_flag_o(uvf), .out_ov_flag_o(ovf), .interrupt_out_n_o(irq_n),
    .system_reset_out_n_o(rst_o_n), .state_o(st));
  task automatic give_verdict();
    if (n_errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] s);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic cy(input int n);
    repeat (n) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask : cy
  task automatic wst(input pss_state_t s, input int lim);
    for (int i = 0; i < lim && st !== s; i++) @(negedge clk_sys_i);
    chk("state", s, st);
  endtask : wst
  task automatic t_boot();
    cy(12);
    rst_n_i <= 1'b1;
    cy(10);
    chk("en_below_mon", '0, en);
    sense.in_above_mon <= 1'b1;
    wst(PSS_ST_ACTIVE, 100);
    cy(3);
    chk("en_active", 5'h1F, en);
    chk("rst_out", 1'b1, rst_o_n);
  endtask : t_boot
  task automatic t_scale();
    ss_fast <= 1'b1;
    goal <= 8'h48;
    cy(12);
    chk("ss_fast", 16'(SS_FAST_CYC), ss_cyc);
    chk("ldo_code", 8'h48, tgt[39:32]);
    chk("ldo_thr", 8'h48, thr[39:32]);
    for (int k = 0; k < 8; k++) begin
      cfg <= pss_scale_cfg_t'(k[2:0]);
      cy(3);
      chk("scale_bus", {3{k == 5}}, scl);
      chk("buck_code", (k == 5) ? 8'h22 : act[7:0], tgt[7:0]);
    end
    sleep_req <= 1'b1;
    wst(PSS_ST_SLEEP, 50);
    cy(3);
    chk("scale_sleep", 3'h7, scl);
    sleep_req <= 1'b0;
    wst(PSS_ST_ACTIVE, 50);
    ds_en <= 1'b1;
    pmode <= 1'b0;
    cy(4);
    chk("pin_filter", PSS_ST_ACTIVE, st);
    wst(PSS_ST_DEEP_SLEEP, 50);
    cy(5);
    chk("scale_deep", '0, scl);
    chk("off_dly_mid", 5'h10, en);
    cy(20);
    chk("off_dly_end", '0, en);
    pmode <= 1'b1;
    ds_en <= 1'b0;
    wst(PSS_ST_ACTIVE, 50);
    cfg <= '0;
    pin_n <= 3'b110;
    cy(3);
    chk("scale_pin", 3'b001, scl);
    pin_n <= '1;
  endtask : t_scale
  task automatic t_inlow();
    sense.in_above_mon <= 1'b0;
    cy(3);
    chk("irq_masked", 1'b1, irq_n);
    chk("low_live", 1'b1, lo_live);
    in_msk <= 1'b0;
    cy(3);
    chk("irq_low", 1'b0, irq_n);
    chk("en_kept", 5'h1F, en);
    sense.in_above_mon <= 1'b1;
    cy(3);
    chk("irq_held", 1'b0, irq_n);
    chk("low_latched", 1'b1, lo_lat);
    rd_req <= 1'b1;
    cy(4);
    chk("low_cleared", 1'b0, lo_lat);
    chk("irq_released", 1'b1, irq_n);
    rd_req <= 1'b0;
    in_msk <= 1'b1;
  endtask : t_inlow
  task automatic t_outflt();
    ov_msk[1] <= 1'b1;
    sense.out_ov[1] <= 1'b1;
    cy(3);
    chk("masked_state", PSS_ST_ACTIVE, st);
    chk("masked_irq", 1'b1, irq_n);
    chk("ov_flag", 5'h02, ovf);
    dis_flt <= 1'b1;
    sense.out_uv[0] <= 1'b1;
    cy(3);
    chk("blocked_state", PSS_ST_ACTIVE, st);
    chk("uv_irq", 1'b0, irq_n);
    chk("uv_flag", 5'h01, uvf);
    dis_flt <= 1'b0;
    wst(PSS_ST_OUT_FAULT, 5);
    sense.out_uv[0] <= 1'b0;
    cy(2);
    chk("fault_rst", 1'b0, rst_o_n);
    chk("fault_en", '0, en);
    wst(PSS_ST_SEQ_START, RST_CYC + 5);
    wst(PSS_ST_ACTIVE, 100);
    sense.out_ov[1] <= 1'b0;
    rd_req <= 1'b1;
    cy(3);
    rd_req <= 1'b0;
  endtask : t_outflt
  task automatic t_ilim();
    ilim_thr <= 3'b001;
    for (int p = 0; p < 16; p++) begin
      sw_cyc <= 3'b001;
      cy(1);
      sw_cyc <= 3'b000;
      cy(1);
      if (p == 14) chk("warn_15", 3'b000, iwarn);
    end
    cy(1);
    chk("warn_16", 3'b001, iwarn);
    chk("warn_irq", 1'b0, irq_n);
    ilim_msk <= 3'b001;
    cy(1);
    chk("warn_masked_irq", 1'b1, irq_n);
    chk("warn_kept", 3'b001, iwarn);
    ilim_thr <= 3'b000;
  endtask : t_ilim
  task automatic t_trip();
    th_msk <= 1'b0;
    sense.therm_warn <= 1'b1;
    sense.therm_shdn <= 1'b1;
    cy(3);
    chk("therm_irq", 1'b0, irq_n);
    chk("therm_flag", 1'b1, twarn);
    chk("therm_en", '0, en);
    sense.therm_shdn <= 1'b0;
    sense.in_uv <= 1'b1;
    wst(PSS_ST_RESET, 5);
    chk("uv_rst", 1'b0, rst_o_n);
    sense.in_uv <= 1'b0;
    wst(PSS_ST_ACTIVE, 100);
    sense.in_ov <= 1'b1;
    wst(PSS_ST_RESET, 5);
    cy(1);
    chk("ov_en", '0, en);
    sense.in_ov <= 1'b0;
    wst(PSS_ST_SEQ_START, 5);
  endtask : t_trip
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc > 20000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    t_boot();
    t_scale();
    t_inlow();
    t_outflt();
    t_ilim();
    t_trip();
    give_verdict();
  end
endmodule : test_pss_supervisor
